// >>> hw/aes_blk_map.svh
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: 200 MHz mclk
// Notes:   byte addresses on a 32-bit APB
`ifndef AES_BLK_MAP_SVH
`define AES_BLK_MAP_SVH
// ********************
// offsets
// ********************
`define OFS_START_TASK   12'h000
`define OFS_STOP_TASK    12'h004
`define OFS_DONE_FLAG    12'h100
`define OFS_ABORT_FLAG   12'h104
`define OFS_DONE_PUB     12'h180
`define OFS_ABORT_PUB    12'h184
`define OFS_INT_SET      12'h304
`define OFS_INT_CLR      12'h308
`define OFS_DATA_PTR     12'h504
// ********************
// fields and resets
// ********************
`define PUB_EN_BIT       31
`define PUB_CH_MSB       7
`define INT_DONE_BIT     0
`define INT_ABORT_BIT    1
`define PUB_RESET        32'h0000_0000
`define KEY_OFS          32'h0000_0000
`define CLEAR_OFS        32'h0000_0010
`define CIPHER_OFS       32'h0000_0020
`define BLOCK_WORDS      4
// ********************
// timing
// ********************
`define RUN_MAX_NS       6200
`define CLK_PERIOD_NS    5
`define RUN_MAX_CYC      (`RUN_MAX_NS / `CLK_PERIOD_NS)
`endif

// >>> hw/aes_blk_pkg.sv
// Purpose: types for the single block encryptor
// Assumes: nothing
// Notes:   states only
package aes_blk_pkg;
   typedef enum logic [2:0] {
      st_idle  = 3'b000,
      st_rdreq = 3'b001,
      st_core  = 3'b010,
      st_wrreq = 3'b011
   } enc_state_t;
endpackage

// >>> hw/single_block_encryptor.sv
// Purpose: event, interrupt and sequencing logic of a one-block encryptor
// Assumes: ram port answers with mem_ack; shared core has a req/done pair plus busy and preempt
// Notes:   the cipher itself sits in the shared core outside this block
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "aes_blk_map.svh"
`default_nettype none

// Behaviour
// - abort publish holds 8-bit channel index
// - publish bit 31 gates abort forwarding
// - set bit 0 enables done interrupt
// - set bit 1 enables abort interrupt
// - clear bit 0 disables done interrupt
// - clear bit 1 disables abort interrupt
// - one block finishes within 6.2 us
// - start fetches, encrypts, writes back, signals done
// - key 0, cleartext 16, ciphertext 32
// - busy core at start raises abort
// - preempt or stop aborts with abort event
module single_block_encryptor
   import aes_blk_pkg::*;
#(
   parameter int RUN_MAX = `RUN_MAX_CYC    // watchdog on one block
) (
   input  wire logic        mclk,          // 200 MHz clock
   input  wire logic        sys_rst,       // async reset, high
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb access phase
   input  wire logic        pwrite,        // apb direction
   input  wire logic [11:0] paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   output logic             mem_req,       // ram access request
   output logic             mem_we,        // ram write
   output logic      [31:0] mem_addr,      // ram byte address
   output logic      [31:0] mem_wdata,     // ram write data
   input  wire logic        mem_ack,       // ram access done
   input  wire logic [31:0] mem_rdata,     // ram read data
   output logic             core_req,      // shared core request
   output logic     [127:0] core_key,      // key to core
   output logic     [127:0] core_din,      // cleartext to core
   input  wire logic        core_busy,     // core used by another unit
   input  wire logic        core_preempt,  // higher priority took core
   input  wire logic        core_done,     // core result valid
   input  wire logic [127:0] core_dout,    // ciphertext from core
   output logic             done_pub,      // done event pulse to fabric
   output logic             abort_pub,     // abort event pulse to fabric
   output logic       [7:0] abort_pub_ch,  // channel of abort pulse
   output logic             irq            // level interrupt
);

   // ********************
   // state
   // ********************
   enc_state_t  st_reg, st_next;           // sequencer
   logic [2:0]  idx_reg, idx_next;         // word index 0..7
   logic [31:0] buf_reg [0:7];             // key then cleartext words
   logic [31:0] buf_next [0:7];
   logic [127:0] ct_reg, ct_next;          // ciphertext
   logic [31:0] ptr_reg, ptr_next;         // data pointer
   logic [31:0] pub_reg, pub_next;         // abort publish config
   logic [31:0] dpub_reg, dpub_next;       // done publish config
   logic [1:0]  inten_reg, inten_next;     // interrupt enables
   logic [1:0]  flag_reg, flag_next;       // event flags
   logic [31:0] wd_reg, wd_next;           // run-time watchdog
   logic        req_reg, req_next;         // ram request
   logic        creq_reg, creq_next;       // core request
   logic        dpub_p_reg, dpub_p_next;   // done pulse
   logic        apub_p_reg, apub_p_next;   // abort pulse
   logic [7:0]  apch_reg, apch_next;       // abort channel
   logic        irq_reg, irq_next;         // interrupt
   logic [31:0] rd_reg, rd_next;           // apb read data
   logic        rdy_reg, rdy_next;         // apb ready
   logic        err_reg, err_next;         // apb error

   // word address inside the data structure
   function automatic logic [31:0] word_addr(input logic [31:0] base,
                                             input logic [31:0] ofs,
                                             input logic [2:0]  w);
      word_addr = base + ofs + {27'h0, w[1:0], 2'b00};
   endfunction

   // apb decode, one-cycle answer
   function automatic logic mapped(input logic [11:0] a);
      case (a)
         `OFS_START_TASK, `OFS_STOP_TASK, `OFS_DONE_FLAG, `OFS_ABORT_FLAG,
         `OFS_DONE_PUB, `OFS_ABORT_PUB, `OFS_INT_SET, `OFS_INT_CLR,
         `OFS_DATA_PTR: mapped = 1'b1;
         default:       mapped = 1'b0;
      endcase
   endfunction

   // ********************
   // next state
   // ********************
   // bus, registers and sequencer in one pass so events and writes agree
   always_comb begin
      logic acc;
      logic wr;
      logic start;
      logic stop;
      logic ev_done;
      logic ev_abort;
      acc       = psel && penable && !rdy_reg;
      // writes land at the edge that completes the transfer, with pready
      wr        = psel && penable && rdy_reg && pwrite;
      start     = wr && paddr == `OFS_START_TASK && pwdata[0];
      stop      = wr && paddr == `OFS_STOP_TASK && pwdata[0];
      ev_done   = 1'b0;
      ev_abort  = 1'b0;
      st_next   = st_reg;
      idx_next  = idx_reg;
      buf_next  = buf_reg;
      ct_next   = ct_reg;
      ptr_next  = ptr_reg;
      pub_next  = pub_reg;
      dpub_next = dpub_reg;
      inten_next = inten_reg;
      wd_next   = wd_reg;
      req_next  = req_reg;
      creq_next = creq_reg;
      rdy_next  = acc;
      err_next  = acc && !mapped(paddr);
      rd_next   = 32'h0000_0000;
      // register writes
      if (wr) begin
         case (paddr)
            `OFS_ABORT_PUB: pub_next = pwdata & 32'h8000_00FF;
            `OFS_DONE_PUB:  dpub_next = pwdata & 32'h8000_00FF;
            `OFS_INT_SET:   inten_next = inten_reg | pwdata[1:0];
            `OFS_INT_CLR:   inten_next = inten_reg & ~pwdata[1:0];
            `OFS_DATA_PTR:  ptr_next = pwdata;
            default: ;
         endcase
      end
      // register reads
      if (acc && !pwrite) begin
         case (paddr)
            `OFS_DONE_FLAG:  rd_next = {31'h0, flag_reg[0]};
            `OFS_ABORT_FLAG: rd_next = {31'h0, flag_reg[1]};
            `OFS_ABORT_PUB:  rd_next = pub_reg;
            `OFS_DONE_PUB:   rd_next = dpub_reg;
            `OFS_INT_SET,
            `OFS_INT_CLR:    rd_next = {30'h0, inten_reg};
            `OFS_DATA_PTR:   rd_next = ptr_reg;
            default:         rd_next = 32'h0000_0000;
         endcase
      end
      // sequencer
      case (st_reg)
         st_idle: begin
            if (start) begin
               if (core_busy) begin
                  ev_abort = 1'b1;
               end else begin
                  st_next  = st_rdreq;
                  idx_next = 3'd0;
                  req_next = 1'b1;
                  wd_next  = 32'h0000_0000;
               end
            end
         end
         st_rdreq: begin
            if (mem_ack) begin
               buf_next[idx_reg] = mem_rdata;
               idx_next = idx_reg + 3'd1;
               if (idx_reg == 3'd7) begin
                  req_next  = 1'b0;
                  creq_next = 1'b1;
                  st_next   = st_core;
               end
            end
         end
         st_core: begin
            if (core_done) begin
               ct_next   = core_dout;
               creq_next = 1'b0;
               req_next  = 1'b1;
               idx_next  = 3'd0;
               st_next   = st_wrreq;
            end
         end
         st_wrreq: begin
            if (mem_ack) begin
               idx_next = idx_reg + 3'd1;
               if (idx_reg == 3'd3) begin
                  req_next = 1'b0;
                  st_next  = st_idle;
                  ev_done  = 1'b1;
               end
            end
         end
         default: st_next = st_idle;
      endcase
      if (st_reg != st_idle) begin
         wd_next = wd_reg + 32'd1;
      end
      // overrun of run time aborts too
      if (st_reg != st_idle && !ev_done &&
          (stop || (st_reg == st_core && core_preempt) ||
           wd_reg >= RUN_MAX - 1)) begin
         st_next   = st_idle;
         req_next  = 1'b0;
         creq_next = 1'b0;
         ev_abort  = 1'b1;
      end
      // flags: hardware set wins over software clear
      flag_next = flag_reg;
      if (wr && paddr == `OFS_DONE_FLAG && !pwdata[0]) flag_next[0] = 1'b0;
      if (wr && paddr == `OFS_ABORT_FLAG && !pwdata[0]) flag_next[1] = 1'b0;
      if (ev_done)  flag_next[0] = 1'b1;
      if (ev_abort) flag_next[1] = 1'b1;
      dpub_p_next = ev_done && dpub_reg[`PUB_EN_BIT];
      apub_p_next = ev_abort && pub_reg[`PUB_EN_BIT];
      apch_next   = pub_reg[`PUB_CH_MSB:0];
      irq_next = |(flag_next & inten_next);
   end

   // ********************
   // registers
   // ********************
   // plain registering of every next value
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= st_idle;
         idx_reg <= 3'd0;
         for (int i = 0; i < 8; i++) buf_reg[i] <= 32'h0000_0000;
         ct_reg <= 128'h0;
         ptr_reg <= 32'h0000_0000;
         pub_reg <= `PUB_RESET;
         dpub_reg <= `PUB_RESET;
         inten_reg <= 2'b00;
         flag_reg <= 2'b00;
         wd_reg <= 32'h0000_0000;
         req_reg <= 1'b0;
         creq_reg <= 1'b0;
         dpub_p_reg <= 1'b0;
         apub_p_reg <= 1'b0;
         apch_reg <= 8'h00;
         irq_reg <= 1'b0;
         rd_reg <= 32'h0000_0000;
         rdy_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         idx_reg <= idx_next;
         buf_reg <= buf_next;
         ct_reg <= ct_next;
         ptr_reg <= ptr_next;
         pub_reg <= pub_next;
         dpub_reg <= dpub_next;
         inten_reg <= inten_next;
         flag_reg <= flag_next;
         wd_reg <= wd_next;
         req_reg <= req_next;
         creq_reg <= creq_next;
         dpub_p_reg <= dpub_p_next;
         apub_p_reg <= apub_p_next;
         apch_reg <= apch_next;
         irq_reg <= irq_next;
         rd_reg <= rd_next;
         rdy_reg <= rdy_next;
         err_reg <= err_next;
      end
   end

   // ********************
   // outputs
   // ********************
   // structure layout offsets
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_addr  <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
         mem_we    <= 1'b0;
      end else begin
         mem_we <= (st_next == st_wrreq);
         if (st_next == st_wrreq) begin
            mem_addr  <= word_addr(ptr_next, `CIPHER_OFS, idx_next);
            mem_wdata <= ct_next[idx_next[1:0]*32 +: 32];
         end else begin
            mem_addr  <= word_addr(ptr_next,
                         idx_next[2] ? `CLEAR_OFS : `KEY_OFS, idx_next);
            mem_wdata <= 32'h0000_0000;
         end
      end
   end

   assign prdata    = rd_reg;
   assign pready    = rdy_reg;
   assign pslverr   = err_reg;
   assign mem_req   = req_reg;
   assign core_req  = creq_reg;
   assign core_key  = {buf_reg[3], buf_reg[2], buf_reg[1], buf_reg[0]};
   assign core_din  = {buf_reg[7], buf_reg[6], buf_reg[5], buf_reg[4]};
   assign done_pub  = dpub_p_reg;
   assign abort_pub = apub_p_reg;
   assign abort_pub_ch = apch_reg;
   assign irq       = irq_reg;

endmodule
`default_nettype wire

// >>> test/single_block_encryptor_properties.sv
// Purpose: port checks on the single block encryptor
// Assumes: one clock, async high reset
// Notes:   shadows copy registers as the bus writes them
`timescale 1ns/1ps
`include "aes_blk_map.svh"
`default_nettype none
module enc_checker #(
   parameter int RUN_MAX = 1240          // watchdog cycles
) (
   input  wire logic        mclk,          // clock
   input  wire logic        sys_rst,       // async reset
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb access
   input  wire logic        pwrite,        // apb direction
   input  wire logic [11:0] paddr,         // apb address
   input  wire logic [31:0] pwdata,        // apb write data
   input  wire logic        pready,        // apb ready
   input  wire logic        pslverr,       // apb error
   input  wire logic        mem_req,       // ram request
   input  wire logic        mem_we,        // ram write
   input  wire logic [31:0] mem_addr,      // ram address
   input  wire logic        core_req,      // core request
   input  wire logic        core_busy,     // core taken elsewhere
   input  wire logic        core_preempt,  // core taken away
   input  wire logic        core_done,     // core result
   input  wire logic        abort_pub,     // abort event
   input  wire logic  [7:0] abort_pub_ch   // abort channel
);
   logic [31:0] pub_reg;   // abort publish shadow
   logic [31:0] ptr_reg;   // pointer shadow
   logic [11:0] run_reg;   // cycles of one busy stretch
   logic        wr_ok;     // accepted write
   logic        start;     // accepted start task
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   assign start = wr_ok && paddr == `OFS_START_TASK && pwdata[0];
   // shadows take a write at the same edge as the design does
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pub_reg <= 32'h0;
         ptr_reg <= 32'h0;
         run_reg <= 12'h0;
      end else begin
         if (wr_ok && paddr == `OFS_ABORT_PUB) pub_reg <= pwdata;
         if (wr_ok && paddr == `OFS_DATA_PTR) ptr_reg <= pwdata;
         run_reg <= (mem_req || core_req) ? run_reg + 12'h1 : 12'h0;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("apb ready late");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_ch; abort_pub |-> abort_pub_ch == pub_reg[7:0]; endproperty
   a_ch: assert property (p_ch) else $error("wrong channel");
   property p_gate; abort_pub |-> pub_reg[31]; endproperty
   a_gate: assert property (p_gate) else $error("ungated event");
   property p_run; run_reg <= RUN_MAX; endproperty
   a_run: assert property (p_run) else $error("block too slow");
   property p_fin; core_done && core_req |-> ##[1:4] mem_req && mem_we;
   endproperty
   a_fin: assert property (p_fin) else $error("no write back");
   property p_rd; mem_req && !mem_we |-> mem_addr - ptr_reg < 32'h20;
   endproperty
   a_rd: assert property (p_rd) else $error("read address");
   property p_wr;
      mem_req && mem_we |-> mem_addr - ptr_reg inside {[32'h20:32'h2C]};
   endproperty
   a_wr: assert property (p_wr) else $error("write address");
   property p_busy; start && core_busy |-> !mem_req [*4]; endproperty
   a_busy: assert property (p_busy) else $error("ran on busy");
   property p_pre;
      core_preempt && core_req && pub_reg[31] |-> ##[1:3] abort_pub;
   endproperty
   a_pre: assert property (p_pre) else $error("no abort");
endmodule
bind single_block_encryptor enc_checker #(.RUN_MAX(RUN_MAX))
   enc_checker_inst (.*);
`default_nettype wire

// >>> test/enc_far_side.sv
// Purpose: data ram and shared core seen by the encryptor
// Assumes: pointer 64-byte aligned, sixteen words
// Notes:   core result is key xor data, not a real cipher
`timescale 1ns/1ps
`default_nettype none
module enc_far_side (
   input  wire logic         mclk,      // clock
   input  wire logic         sys_rst,   // async reset
   input  wire logic  [3:0]  lat,       // answer delay
   input  wire logic         mem_req,   // ram request
   input  wire logic         mem_we,    // ram write
   input  wire logic [31:0]  mem_addr,  // ram address
   input  wire logic [31:0]  mem_wdata, // ram write data
   output logic              mem_ack,   // ram done
   output logic      [31:0]  mem_rdata, // ram read data
   input  wire logic         core_req,  // core request
   input  wire logic [127:0] core_key,  // key
   input  wire logic [127:0] core_din,  // cleartext
   output logic              core_done, // result pulse
   output logic     [127:0]  core_dout  // result
);
   logic [31:0] mem [0:15];  // ram, bench preloads it
   logic  [3:0] m_cnt;       // ram wait count
   logic  [3:0] c_cnt;       // core wait count
   // data lines toggle when idle so stale values never look valid
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         {mem_ack, core_done, m_cnt, c_cnt} <= '0;
         mem_rdata <= 32'h0;
         core_dout <= 128'h0;
      end else begin
         mem_ack <= 1'b0;
         core_done <= 1'b0;
         mem_rdata <= ~mem_rdata;
         core_dout <= ~core_dout;
         m_cnt <= (mem_req && !mem_ack) ? m_cnt + 4'h1 : 4'h0;
         c_cnt <= (core_req && !core_done) ? c_cnt + 4'h1 : 4'h0;
         if (mem_req && !mem_ack && m_cnt == lat) begin
            mem_ack <= 1'b1;
            m_cnt <= 4'h0;
            if (mem_we) mem[mem_addr[5:2]] <= mem_wdata;
            else mem_rdata <= mem[mem_addr[5:2]];
         end
         if (core_req && !core_done && c_cnt == lat + 4'h4) begin
            core_done <= 1'b1;
            core_dout <= core_key ^ core_din;
         end
      end
   end
endmodule
`default_nettype wire

// >>> test/single_block_encryptor_tb_top.sv
// Purpose: self-checking bench of the single block encryptor
// Assumes: 200 MHz clock, ram pointer 0x100
// Notes:   register rows first, then runs and aborts
`timescale 1ns/1ps
`include "aes_blk_map.svh"
`default_nettype none
module single_block_encryptor_tb_top;
   localparam int RUN = 1240;               // watchdog cycles
   logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic mem_req, mem_we, mem_ack, core_req, core_busy, core_preempt;
   logic core_done, done_pub, abort_pub, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
   logic [127:0] core_key, core_din, core_dout;
   logic [7:0] abort_pub_ch, last_ch;
   logic [3:0] lat;
   int fail_count, n_checks, n_abort, n_done, i, k;
   typedef struct packed { logic [11:0] wa, ra; logic [31:0] wd, ex; } row_t;
   row_t rows [10] = '{
      '{12'h184, 12'h184, 32'hFFFFFFFF, 32'h800000FF},
      '{12'h184, 12'h184, 32'h00000005, 32'h00000005},
      '{12'h304, 12'h304, 32'h00000001, 32'h00000001},
      '{12'h304, 12'h304, 32'h00000000, 32'h00000001},
      '{12'h304, 12'h304, 32'h00000002, 32'h00000003},
      '{12'h308, 12'h308, 32'h00000000, 32'h00000003},
      '{12'h308, 12'h304, 32'h00000001, 32'h00000002},
      '{12'h308, 12'h308, 32'h00000002, 32'h00000000},
      '{12'h504, 12'h504, 32'h00000100, 32'h00000100},
      '{12'hFFC, 12'hFFC, 32'hFFFFFFFF, 32'h00000000}};
   single_block_encryptor #(.RUN_MAX(RUN)) single_block_encryptor_inst (.*);
   enc_far_side enc_far_side_inst (.*);
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // count abort and done events seen by the fabric
   always @(posedge mclk) begin
      if (abort_pub === 1'b1) begin
         n_abort++;
         last_ch = abort_pub_ch;
      end
      if (done_pub === 1'b1) n_done++;
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task bound(input int n, input int lim);
      if (n >= lim) begin
         fail_count++;
         $display("MISMATCH wait exp answer got timeout");
         tally_and_finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until ready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      bound(n, 50);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   initial begin
      {sys_rst, psel, penable, pwrite, core_busy, core_preempt} = 6'b100000;
      {paddr, pwdata, lat, fail_count, n_checks, n_abort, n_done} = '0;
      for (i = 0; i < 16; i++) begin
         enc_far_side_inst.mem[i] = 32'h01010101 * i;
      end
      cyc(8);
      sys_rst <= 1'b0;
      apb(0, `OFS_ABORT_PUB, 0);
      chk("pub reset", 32'h0, rd);
      apb(0, `OFS_INT_SET, 0);
      chk("en reset", 32'h0, rd);
      for (k = 0; k < 10; k++) begin
         apb(1, rows[k].wa, rows[k].wd);
         apb(0, rows[k].ra, 32'h0);
         chk("row", rows[k].ex, rd);
      end
      chk("slverr", 32'h1, {31'h0, err});
      $display("test registers done");
      apb(1, `OFS_ABORT_PUB, 32'h80000005);
      apb(1, `OFS_DONE_PUB, 32'h80000000);
      apb(1, `OFS_INT_SET, 32'h3);
      lat <= 4'h2;
      apb(1, `OFS_START_TASK, 32'h1);
      for (i = 0; i < RUN && irq !== 1'b1; i++) @(posedge mclk);
      bound(i, RUN);
      for (k = 0; k < 4; k++) begin
         rd = enc_far_side_inst.mem[k] ^ enc_far_side_inst.mem[k+4];
         chk("cipher", rd, enc_far_side_inst.mem[k+8]);
      end
      apb(0, `OFS_DONE_FLAG, 0);
      chk("done flag", 32'h1, rd);
      chk("done event", 32'h1, n_done);
      apb(1, `OFS_DONE_FLAG, 0);
      cyc(2);
      chk("irq off", 32'h0, {31'h0, irq});
      $display("test run done");
      core_busy <= 1'b1;
      apb(1, `OFS_START_TASK, 32'h1);
      cyc(20);
      core_busy <= 1'b0;
      chk("busy abort", 32'h1, n_abort);
      chk("channel", 32'h5, {24'h0, last_ch});
      apb(1, `OFS_ABORT_FLAG, 0);
      lat <= 4'h0;
      apb(1, `OFS_START_TASK, 32'h1);
      for (i = 0; i < 100 && core_req !== 1'b1; i++) @(posedge mclk);
      bound(i, 100);
      core_preempt <= 1'b1;
      cyc(1);
      core_preempt <= 1'b0;
      cyc(10);
      chk("preempt abort", 32'h2, n_abort);
      apb(1, `OFS_ABORT_FLAG, 0);
      apb(1, `OFS_ABORT_PUB, 32'h5);
      apb(1, `OFS_START_TASK, 32'h1);
      apb(1, `OFS_STOP_TASK, 32'h1);
      cyc(10);
      chk("gated", 32'h2, n_abort);
      apb(0, `OFS_ABORT_FLAG, 0);
      chk("stop flag", 32'h1, rd);
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1, `OFS_INT_CLR, 32'h2);
      cyc(2);
      chk("masked", 32'h0, {31'h0, irq});
      $display("test aborts done");
      // reset in the middle of a run must drop the ram request at once
      apb(1, `OFS_START_TASK, 32'h1);
      cyc(3);
      sys_rst <= 1'b1;
      cyc(2);
      sys_rst <= 1'b0;
      chk("rst req", 32'h0, {31'h0, mem_req});
      apb(0, `OFS_INT_SET, 0);
      chk("rst en", 32'h0, rd);
      apb(0, `OFS_DATA_PTR, 0);
      chk("rst ptr", 32'h0, rd);
      $display("test reset done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
